// File: src/dma_pkg.sv
// Constants and types shared by the banked data memory addressing unit
package dma_pkg;

    // ************************************************************
    // Special function addresses
    // ************************************************************
    localparam logic [7:0] WINDOW_A_ADDR   = 8'h00;
    localparam logic [7:0] POINTER_A_ADDR  = 8'h01;
    localparam logic [7:0] WINDOW_B_ADDR   = 8'h02;
    localparam logic [7:0] POINTER_B_ADDR  = 8'h03;
    localparam logic [7:0] BANK_SEL_ADDR   = 8'h04;
    localparam logic [7:0] ACCUM_ADDR      = 8'h05;
    localparam logic [7:0] BANK_COUNT_ADDR = 8'h06;
    localparam logic [7:0] GP_BASE_ADDR    = 8'h80;

    // ************************************************************
    // Layout, reset values and field positions
    // ************************************************************
    localparam int         BANK_WORDS      = 128;
    localparam int         RAM_WORDS       = 512;
    localparam logic [7:0] BANK_SEL_RESET  = 8'h00;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam logic [7:0] BANK_MASK_TWO   = 8'h01;
    localparam logic [7:0] BANK_MASK_MORE  = 8'h03;
    localparam int         BANK_FIELD_LSB  = 0;
    localparam logic [7:0] LCD_SIZE_TWO    = 8'h19;
    localparam logic [7:0] LCD_SIZE_THREE  = 8'h25;
    localparam logic [7:0] LCD_SIZE_FOUR   = 8'h31;

    // ************************************************************
    // Core access operations
    // ************************************************************
    typedef enum logic [2:0] {
        OP_LOAD,
        OP_STORE,
        OP_SET_BIT,
        OP_CLR_BIT,
        OP_INC,
        OP_DEC,
        OP_ALU
    } dma_op_type;

    typedef struct packed {
        logic [RAM_WORDS-1:0][7:0] ram;
        logic [7:0]                pointerA;
        logic [7:0]                pointerB;
        logic [7:0]                bankSel;
        logic [7:0]                accum;
        logic [7:0]                rdData;
        logic                      rdValid;
        logic [2:0]                emuSync;
        logic                      emuStable;
        logic [2:0]                dbgClkSync;
        logic [2:0]                dbgDatSync;
        logic                      dbgClk;
        logic                      dbgDat;
        logic                      sharedPinEn;
    } dma_state_type;

endpackage

// File: src/dma_banked_memory.sv
// Banked data memory with direct and indirect addressing, bank select and accumulator
`timescale 1ns/100ps
module dma_banked_memory #(
    parameter int NUM_BANKS = 4                 // Variant size: 2, 3 or 4 banks
) (
    input  wire logic       mclk,               // System clock
    input  wire logic       resetn,             // Power-on reset, async, active low
    input  wire logic       chipReset,          // Other reset source, one-cycle pulse
    input  wire logic       chipResetWdtPd,     // Qualifies chipReset as watchdog in power down
    input  wire logic       accReq,             // Core access request
    input  wire logic [2:0] accOp,              // Access operation
    input  wire logic [7:0] accAddr,            // Direct data memory address
    input  wire logic [2:0] accBit,             // Bit index for set or clear
    input  wire logic [7:0] aluResult,          // ALU result for the accumulator
    output logic [7:0]      rdData,             // Read data of last load
    output logic            rdValid,            // Read data valid pulse
    output logic [7:0]      accumulatorReg,     // Accumulator contents
    output logic [7:0]      dataBankSelect,     // Bank select register value
    output logic [7:0]      progBankSelect,     // Bank select for program memory
    input  wire logic       emuMode,            // Emulation part strap, asynchronous
    input  wire logic       debugClockPin,      // Debugger clock pin
    input  wire logic       debugDataPinIn,     // Debug data pin level
    output logic            debugDataPinOut,    // Debug data pin drive value
    output logic            debugDataPinOe,     // Debug data pin drive enable
    output logic            debugClockSeen,     // Synchronised debugger clock
    output logic            debugDataSeen,      // Synchronised debugger data
    output logic            sharedPinEn         // Normal shared pin functions enabled
);

    // ************************************************************
    // Variant constants
    // ************************************************************
    localparam logic [7:0] LCD_SIZE  = (NUM_BANKS == 2) ? dma_pkg::LCD_SIZE_TWO :
                                       (NUM_BANKS == 3) ? dma_pkg::LCD_SIZE_THREE : dma_pkg::LCD_SIZE_FOUR;
    localparam logic [7:0] BANK_MASK = (NUM_BANKS == 2) ? dma_pkg::BANK_MASK_TWO : dma_pkg::BANK_MASK_MORE;
    localparam logic [7:0] BANK_CNT  = 8'(NUM_BANKS);

    dma_pkg::dma_state_type q;
    dma_pkg::dma_state_type d;

    dma_pkg::dma_op_type op;
    logic       isIndirect;
    logic [1:0] tgtBank;
    logic [7:0] tgtOff;
    logic       tgtSfr;
    logic       tgtRam;
    logic [8:0] ramIdx;
    logic [7:0] curVal;
    logic [7:0] newVal;
    logic       doWrite;
    logic [7:0] offInBank;

    assign op = dma_pkg::dma_op_type'(accOp);

    // ************************************************************
    // Address resolution
    // ************************************************************
    always_comb begin
        isIndirect = 1'b0;
        tgtBank    = 2'b00;
        tgtOff     = accAddr;
        if (accAddr == dma_pkg::WINDOW_A_ADDR) begin
            isIndirect = 1'b1;
            tgtBank    = 2'b00;
            tgtOff     = q.pointerA;
        end else if (accAddr == dma_pkg::WINDOW_B_ADDR) begin
            isIndirect = 1'b1;
            tgtBank    = q.bankSel[1:0];
            tgtOff     = q.pointerB;
        end
        offInBank = tgtOff - dma_pkg::GP_BASE_ADDR;
        tgtSfr    = (tgtOff < dma_pkg::GP_BASE_ADDR);
        ramIdx    = {tgtBank, tgtOff[6:0]};
        tgtRam    = 1'b0;
        if (!tgtSfr) begin
            case (tgtBank)
                2'b00:   tgtRam = 1'b1;
                2'b01:   tgtRam = (offInBank < LCD_SIZE);
                2'b10:   tgtRam = (NUM_BANKS >= 3);
                2'b11:   tgtRam = (NUM_BANKS == 4);
                default: tgtRam = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Current value of the target
    // ************************************************************
    always_comb begin
        curVal = dma_pkg::ZERO_BYTE;
        if (tgtRam) begin
            curVal = q.ram[ramIdx];
        end else if (tgtSfr) begin
            case (tgtOff)
                dma_pkg::POINTER_A_ADDR:  curVal = q.pointerA;
                dma_pkg::POINTER_B_ADDR:  curVal = q.pointerB;
                dma_pkg::BANK_SEL_ADDR:   curVal = q.bankSel;
                dma_pkg::ACCUM_ADDR:      curVal = q.accum;
                dma_pkg::BANK_COUNT_ADDR: curVal = BANK_CNT;
                default:                  curVal = dma_pkg::ZERO_BYTE;
            endcase
        end
    end

    // ************************************************************
    // Operation: new value and write qualification
    // ************************************************************
    always_comb begin
        newVal  = curVal;
        doWrite = 1'b0;
        if (accReq) begin
            case (op)
                dma_pkg::OP_STORE: begin
                    newVal  = q.accum;
                    doWrite = 1'b1;
                end
                dma_pkg::OP_SET_BIT: begin
                    newVal         = curVal;
                    newVal[accBit] = 1'b1;
                    doWrite        = 1'b1;
                end
                dma_pkg::OP_CLR_BIT: begin
                    newVal         = curVal;
                    newVal[accBit] = 1'b0;
                    doWrite        = 1'b1;
                end
                dma_pkg::OP_INC: begin
                    newVal  = curVal + 8'h01;
                    doWrite = 1'b1;
                end
                dma_pkg::OP_DEC: begin
                    newVal  = curVal - 8'h01;
                    doWrite = 1'b1;
                end
                default: begin
                    newVal  = curVal;
                    doWrite = 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d         = q;
        d.rdValid = 1'b0;
        if (accReq && op == dma_pkg::OP_LOAD) begin
            d.rdData  = curVal;
            d.rdValid = 1'b1;
            d.accum   = curVal;
        end
        if (accReq && op == dma_pkg::OP_ALU) begin
            d.accum = aluResult;
        end
        if (doWrite) begin
            if (tgtRam) begin
                d.ram[ramIdx] = newVal;
            end else if (tgtSfr) begin
                // Window and read-only locations fall through untouched
                case (tgtOff)
                    dma_pkg::POINTER_A_ADDR: d.pointerA = newVal;
                    dma_pkg::POINTER_B_ADDR: d.pointerB = newVal;
                    dma_pkg::BANK_SEL_ADDR:  d.bankSel  = newVal & BANK_MASK;
                    dma_pkg::ACCUM_ADDR:     d.accum    = newVal;
                    default:                 d.pointerA = q.pointerA;
                endcase
            end
        end
        // Reset source wins over a same-cycle write to the bank select
        if (chipReset && !chipResetWdtPd) begin
            d.bankSel = dma_pkg::BANK_SEL_RESET;
        end else if (chipReset) begin
            d.bankSel = q.bankSel;
        end
        // Three-stage capture; a change counts once the last two agree
        d.emuSync    = {q.emuSync[1:0], emuMode};
        d.dbgClkSync = {q.dbgClkSync[1:0], debugClockPin};
        d.dbgDatSync = {q.dbgDatSync[1:0], debugDataPinIn};
        if (q.emuSync[2] == q.emuSync[1]) begin
            d.emuStable = q.emuSync[2];
        end
        if (q.dbgClkSync[2] == q.dbgClkSync[1]) begin
            d.dbgClk = q.dbgClkSync[2];
        end
        if (q.dbgDatSync[2] == q.dbgDatSync[1]) begin
            d.dbgDat = q.dbgDatSync[2];
        end
        d.sharedPinEn = !q.emuStable;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q             <= '0;
            q.bankSel     <= dma_pkg::BANK_SEL_RESET;
            q.sharedPinEn <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rdData          = q.rdData;
    assign rdValid         = q.rdValid;
    assign accumulatorReg  = q.accum;
    assign dataBankSelect  = q.bankSel;
    assign progBankSelect  = q.bankSel;
    // Debug protocol is outside this block, so the data pin is only observed
    assign debugDataPinOut = 1'b0;
    assign debugDataPinOe  = 1'b0;
    assign debugClockSeen  = q.dbgClk;
    assign debugDataSeen   = q.dbgDat;
    assign sharedPinEn     = q.sharedPinEn;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    a_bank_reset_clear: assert property (chipReset && !chipResetWdtPd |=> dataBankSelect == 8'h00)
        else $error("bank select not cleared by reset");
    a_bank_wdt_keep: assert property (chipReset && chipResetWdtPd |=> $stable(dataBankSelect))
        else $error("bank select changed on watchdog power down reset");
    a_bank_upper_zero: assert property ((dataBankSelect & ~BANK_MASK) == 8'h00)
        else $error("unimplemented bank select bits set");
    a_prog_bank_same: assert property (progBankSelect == dataBankSelect)
        else $error("program and data bank select differ");
    a_alu_to_acc: assert property (accReq && op == dma_pkg::OP_ALU && !(doWrite) |=>
                                   accumulatorReg == $past(aluResult))
        else $error("accumulator missed ALU result");
    a_unused_sfr_zero: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                        accAddr > dma_pkg::BANK_COUNT_ADDR &&
                                        accAddr < dma_pkg::GP_BASE_ADDR |=> rdValid && rdData == 8'h00)
        else $error("unused special address read nonzero");
    a_window_self_zero: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                         accAddr == dma_pkg::WINDOW_A_ADDR &&
                                         (q.pointerA == dma_pkg::WINDOW_A_ADDR ||
                                          q.pointerA == dma_pkg::WINDOW_B_ADDR) |=> rdData == 8'h00)
        else $error("window self read nonzero");
    a_bit_set_direct: assert property (accReq && op == dma_pkg::OP_SET_BIT &&
                                       accAddr >= dma_pkg::GP_BASE_ADDR && !chipReset |=>
                                       q.ram[{2'b00, $past(accAddr[6:0])}][$past(accBit)] == 1'b1)
        else $error("direct bit set missed bank 0 location");
    a_pointer_inc: assert property (accReq && op == dma_pkg::OP_INC && accAddr == dma_pkg::POINTER_A_ADDR |=>
                                    q.pointerA == $past(q.pointerA) + 8'h01)
        else $error("pointer increment wrong");
    a_pointer_dec: assert property (accReq && op == dma_pkg::OP_DEC && accAddr == dma_pkg::POINTER_A_ADDR |=>
                                    q.pointerA == $past(q.pointerA) - 8'h01)
        else $error("pointer decrement wrong");
    a_shared_pin: assert property ($past(q.emuStable) |-> !sharedPinEn)
        else $error("shared pins active in emulation");

    // ************************************************************
    // Assertions: addressing paths
    // ************************************************************
    // Expected data comes from the flop image one cycle back, not from curVal
    a_direct_bank0: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                     accAddr >= dma_pkg::GP_BASE_ADDR |=>
                                     rdData == $past(q.ram[{2'b00, accAddr[6:0]}]))
        else $error("direct load left bank 0");
    a_window_a_bank0: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                       accAddr == dma_pkg::WINDOW_A_ADDR &&
                                       q.pointerA >= dma_pkg::GP_BASE_ADDR |=>
                                       rdData == $past(q.ram[{2'b00, q.pointerA[6:0]}]))
        else $error("first window left bank 0");
    a_window_b_bank: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                      accAddr == dma_pkg::WINDOW_B_ADDR && tgtRam |=>
                                      rdData == $past(q.ram[{q.bankSel[1:0], q.pointerB[6:0]}]))
        else $error("second window missed banked location");
    // Display bank is shorter than the others; the tail must read as empty
    a_lcd_limit: assert property (accReq && op == dma_pkg::OP_LOAD &&
                                  accAddr == dma_pkg::WINDOW_B_ADDR && q.bankSel[1:0] == 2'b01 &&
                                  q.pointerB >= (dma_pkg::GP_BASE_ADDR + LCD_SIZE) |=>
                                  rdData == 8'h00)
        else $error("display bank tail read nonzero");
    a_bit_clr_keep: assert property (accReq && op == dma_pkg::OP_CLR_BIT &&
                                     accAddr >= dma_pkg::GP_BASE_ADDR |=>
                                     q.ram[{2'b00, $past(accAddr[6:0])}] ==
                                     ($past(q.ram[{2'b00, accAddr[6:0]}]) & ~(8'h01 << $past(accBit))))
        else $error("bit clear disturbed other bits");

    // ************************************************************
    // Assertions: accumulator and read-only space
    // ************************************************************
    a_store_via_acc: assert property (accReq && op == dma_pkg::OP_STORE &&
                                      accAddr >= dma_pkg::GP_BASE_ADDR |=>
                                      q.ram[{2'b00, $past(accAddr[6:0])}] == $past(q.accum))
        else $error("store did not take the accumulator");
    a_load_to_acc: assert property (accReq && op == dma_pkg::OP_LOAD |=>
                                    accumulatorReg == rdData)
        else $error("load did not pass through the accumulator");
    a_rdvalid_once: assert property (rdValid |->
                                     $past(accReq) && $past(op) == dma_pkg::OP_LOAD)
        else $error("read valid without a load");
    // A write to the bank count must leave the bank select and the accumulator alone
    a_readonly_keep: assert property (accReq && op == dma_pkg::OP_STORE &&
                                      accAddr == dma_pkg::BANK_COUNT_ADDR && !chipReset |=>
                                      $stable(dataBankSelect) && $stable(accumulatorReg))
        else $error("read-only location accepted a write");
    a_bank_mask_write: assert property (accReq && op == dma_pkg::OP_STORE &&
                                        accAddr == dma_pkg::BANK_SEL_ADDR && !chipReset |=>
                                        dataBankSelect == ($past(q.accum) & BANK_MASK))
        else $error("bank select write not masked");

    // ************************************************************
    // Assertions: debug pins
    // ************************************************************
    a_dbg_clk_agree: assert property ($changed(debugClockSeen) |->
                                      $past(q.dbgClkSync[2]) == $past(q.dbgClkSync[1]))
        else $error("debug clock accepted before stages agreed");
    a_dbg_pin_idle: assert property (!debugDataPinOe)
        else $error("debug data pin driven");

    c_indirect_b: cover property (accReq && accAddr == dma_pkg::WINDOW_B_ADDR && q.bankSel[1:0] == 2'b11);
    c_lcd_write: cover property (accReq && op == dma_pkg::OP_STORE && tgtRam && tgtBank == 2'b01);
    c_wdt_reset: cover property (chipReset && chipResetWdtPd && q.bankSel != 8'h00);
    c_ptr_wrap: cover property (accReq && op == dma_pkg::OP_INC && accAddr == dma_pkg::POINTER_A_ADDR &&
                                q.pointerA == 8'hFF);
    c_window_self: cover property (accReq && accAddr == dma_pkg::WINDOW_A_ADDR &&
                                   q.pointerA == dma_pkg::WINDOW_A_ADDR);

endmodule

// File: verif/tb.sv
// Self-checking testbench for the banked data memory addressing unit
`timescale 1ns/100ps
module tb;

    // ************************************************************
    // Clock, reset and stimulus signals
    // ************************************************************
    logic                   mclk;
    logic                   resetn;
    logic                   chipReset;
    logic                   chipResetWdtPd;
    logic                   accReq;
    dma_pkg::dma_op_type    accOp;
    logic [7:0]             accAddr;
    logic [2:0]             accBit;
    logic [7:0]             aluResult;
    logic [7:0]             rdData;
    logic                   rdValid;
    logic [7:0]             accumulatorReg;
    logic [7:0]             dataBankSelect;
    logic [7:0]             progBankSelect;
    logic                   emuMode;
    logic                   debugClockPin;
    logic                   debugDataPinIn;
    logic                   debugDataPinOut;
    logic                   debugDataPinOe;
    logic                   debugClockSeen;
    logic                   debugDataSeen;
    logic                   sharedPinEn;
    int                     bad_count;
    int                     n_checks;
    int                     seed;
    int                     i;
    logic [7:0]             v;
    logic [7:0]             pat [4];
    logic [7:0]             expQ [$];

    dma_banked_memory #(.NUM_BANKS(4)) dut (
        .mclk(mclk), .resetn(resetn), .chipReset(chipReset), .chipResetWdtPd(chipResetWdtPd),
        .accReq(accReq), .accOp(accOp), .accAddr(accAddr), .accBit(accBit), .aluResult(aluResult),
        .rdData(rdData), .rdValid(rdValid), .accumulatorReg(accumulatorReg),
        .dataBankSelect(dataBankSelect), .progBankSelect(progBankSelect), .emuMode(emuMode),
        .debugClockPin(debugClockPin), .debugDataPinIn(debugDataPinIn), .debugDataPinOut(debugDataPinOut),
        .debugDataPinOe(debugDataPinOe), .debugClockSeen(debugClockSeen), .debugDataSeen(debugDataSeen),
        .sharedPinEn(sharedPinEn)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        if (bad_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One request per edge; back to back calls give back to back requests
    task automatic req(input dma_pkg::dma_op_type op, input logic [7:0] a,
                       input logic [2:0] b = 3'h0, input logic [7:0] alu = 8'h00);
        @(posedge mclk);
        accReq    <= 1'b1;
        accOp     <= op;
        accAddr   <= a;
        accBit    <= b;
        aluResult <= alu;
    endtask

    // Stores must go through the accumulator, so load it first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req(dma_pkg::OP_ALU, 8'h00, 3'h0, d);
        req(dma_pkg::OP_STORE, a);
    endtask

    task automatic ld(input logic [7:0] a, input logic [7:0] exp);
        req(dma_pkg::OP_LOAD, a);
        expQ.push_back(exp);
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            accReq <= 1'b0;
        end
        @(negedge mclk);
    endtask

    // ************************************************************
    // Read data monitor
    // ************************************************************
    // Sampled mid-cycle so the flop has settled
    always @(negedge mclk) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                bad_count++;
                $display("[ERR] t=%0t seen=%h exp=none", $time, rdData);
            end else begin
                check(rdData, expQ.pop_front());
            end
        end
    end

    initial begin
        #200000;
        bad_count++;
        complete_run();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        seed = 32'h6a302613;
        bad_count = 0;
        n_checks = 0;
        resetn = 1'b0;
        chipReset = 1'b0;
        chipResetWdtPd = 1'b0;
        accReq = 1'b0;
        accOp = dma_pkg::OP_LOAD;
        accAddr = 8'h00;
        accBit = 3'h0;
        aluResult = 8'h00;
        emuMode = 1'b0;
        debugClockPin = 1'b0;
        debugDataPinIn = 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        check(dataBankSelect, 8'h00);
        check(accumulatorReg, 8'h00);
        check({7'h00, sharedPinEn}, 8'h01);
        check({7'h00, debugDataPinOe}, 8'h00);
        v = $random(seed);
        wr(8'h85, v);
        ld(8'h85, v);
        for (i = 0; i < 8; i++) begin
            req(dma_pkg::OP_SET_BIT, 8'h85, i[2:0]);
            v[i] = 1'b1;
            ld(8'h85, v);
            req(dma_pkg::OP_CLR_BIT, 8'h85, 3'(7 - i));
            v[7 - i] = 1'b0;
            ld(8'h85, v);
        end
        wr(dma_pkg::BANK_SEL_ADDR, 8'hFF);
        idle(1);
        check(dataBankSelect, 8'h03);
        check(progBankSelect, 8'h03);
        ld(dma_pkg::BANK_SEL_ADDR, 8'h03);
        wr(dma_pkg::POINTER_B_ADDR, 8'hA0);
        for (i = 0; i < 4; i++) begin
            pat[i] = $random(seed);
            wr(dma_pkg::BANK_SEL_ADDR, i[7:0]);
            wr(dma_pkg::WINDOW_B_ADDR, pat[i]);
        end
        for (i = 0; i < 4; i++) begin
            wr(dma_pkg::BANK_SEL_ADDR, i[7:0]);
            ld(dma_pkg::WINDOW_B_ADDR, pat[i]);
        end
        ld(8'hA0, pat[0]);
        wr(dma_pkg::POINTER_A_ADDR, 8'hA0);
        ld(dma_pkg::WINDOW_A_ADDR, pat[0]);
        wr(dma_pkg::POINTER_B_ADDR, dma_pkg::BANK_SEL_ADDR);
        ld(dma_pkg::WINDOW_B_ADDR, 8'h03);
        wr(dma_pkg::BANK_SEL_ADDR, 8'h01);
        wr(dma_pkg::POINTER_B_ADDR, 8'hB0);
        wr(dma_pkg::WINDOW_B_ADDR, 8'h5A);
        ld(dma_pkg::WINDOW_B_ADDR, 8'h5A);
        wr(dma_pkg::POINTER_B_ADDR, 8'hB1);
        wr(dma_pkg::WINDOW_B_ADDR, 8'hA5);
        ld(dma_pkg::WINDOW_B_ADDR, 8'h00);
        wr(dma_pkg::POINTER_A_ADDR, dma_pkg::WINDOW_A_ADDR);
        wr(dma_pkg::WINDOW_A_ADDR, 8'h77);
        ld(dma_pkg::WINDOW_A_ADDR, 8'h00);
        wr(dma_pkg::POINTER_A_ADDR, dma_pkg::WINDOW_B_ADDR);
        ld(dma_pkg::WINDOW_A_ADDR, 8'h00);
        wr(dma_pkg::POINTER_A_ADDR, 8'hFF);
        req(dma_pkg::OP_INC, dma_pkg::POINTER_A_ADDR);
        ld(dma_pkg::POINTER_A_ADDR, 8'h00);
        req(dma_pkg::OP_DEC, dma_pkg::POINTER_A_ADDR);
        req(dma_pkg::OP_DEC, dma_pkg::POINTER_A_ADDR);
        ld(dma_pkg::POINTER_A_ADDR, 8'hFE);
        for (i = 7; i < 128; i += 15) begin
            wr(i[7:0], 8'hFF);
            ld(i[7:0], 8'h00);
        end
        wr(dma_pkg::BANK_COUNT_ADDR, 8'h00);
        ld(dma_pkg::BANK_COUNT_ADDR, 8'h04);
        idle(2);
        v = $random(seed);
        req(dma_pkg::OP_ALU, 8'h00, 3'h0, v);
        idle(1);
        check(accumulatorReg, v);
        ld(8'hA0, pat[0]);
        idle(1);
        check(accumulatorReg, pat[0]);
        wr(dma_pkg::BANK_SEL_ADDR, 8'h02);
        idle(1);
        for (i = 0; i < 2; i++) begin
            @(posedge mclk);
            chipReset <= 1'b1;
            chipResetWdtPd <= (i == 0);
            @(posedge mclk);
            chipReset <= 1'b0;
            chipResetWdtPd <= 1'b0;
            @(negedge mclk);
            check(dataBankSelect, (i == 0) ? 8'h02 : 8'h00);
        end
        @(posedge mclk);
        emuMode <= 1'b1;
        debugClockPin <= 1'b1;
        debugDataPinIn <= 1'b1;
        for (i = 0; i < 10 && (sharedPinEn !== 1'b0 || debugClockSeen !== 1'b1); i++) begin
            @(negedge mclk);
        end
        @(negedge mclk);
        check({7'h00, sharedPinEn}, 8'h00);
        check({7'h00, debugClockSeen}, 8'h01);
        check({7'h00, debugDataSeen}, 8'h01);
        check({7'h00, debugDataPinOe}, 8'h00);
        idle(3);
        check(8'(expQ.size()), 8'h00);
        complete_run();
    end

endmodule
